// *** hw/qpb_pin_if.sv ***
// interface: one port's pin view between the bank and its pin drivers
interface qpb_pin_if;
  import qpb_pkg::*;
  logic [7:0] drive_low;
  logic [7:0] boost;
  logic [7:0] pin_sync;
  modport bank (output drive_low, output boost, input pin_sync);
  modport pad (input drive_low, input boost, output pin_sync);
endinterface : qpb_pin_if

// *** hw/qpb_pin_sync.sv ***
// module: three-flop pin synchroniser, a change counts when flops two and three agree
module qpb_pin_sync
  import qpb_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;

  assign lvl_d = (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & lvl_q);
  assign pin_level = lvl_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lvl_q <= '1;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
endmodule : qpb_pin_sync

// *** hw/qpb_pkg.sv ***
// package: shared constants and types for the quasi-bidirectional port bank
package qpb_pkg;
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // machine cycle: six states, two phases each, one oscillator period per phase
  localparam int PHASES_PER_CYCLE = 12;
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S1P2 = 4'h1;
  localparam logic [3:0] PH_S6P2 = 4'hB;
  // strong pull-up pulse on a CMOS 0-to-1 change, in oscillator periods
  localparam int BOOST_OSC_PERIODS = 2;
  // port selects
  localparam logic [1:0] PORT_ZERO = 2'h0;
  localparam logic [1:0] PORT_ONE = 2'h1;
  localparam logic [1:0] PORT_TWO = 2'h2;
  localparam logic [1:0] PORT_THREE = 2'h3;
  // read source selects
  typedef enum logic [1:0] {QPB_RD_NONE, QPB_RD_LATCH, QPB_RD_PIN} qpb_rdsel_t;
  // port 3 and port 1 bit positions of alternate functions
  localparam int P3_SER_IN = 0;
  localparam int P3_SER_OUT = 1;
  localparam int P3_IRQ_A = 2;
  localparam int P3_IRQ_B = 3;
  localparam int P3_TMR_A = 4;
  localparam int P3_TMR_B = 5;
  localparam int P3_WR_STB = 6;
  localparam int P3_RD_STB = 7;
  localparam int P1_TMR_C = 0;
  localparam int P1_TMR_C_TRIG = 1;
endpackage : qpb_pkg

// *** hw/qpb_port_bank.sv ***
// module: four 8-bit quasi-bidirectional ports with latches, read paths and bus muxing
// Overview of operation
// - port zero carries address low, then data
// - port two: high address if 16-bit, else latch
// - port three and p1.0/1 carry special functions
// - alternate function needs latch one, else low
// - write-latch loads; read latch or pin
// - external access: p2 latch kept, p0 all ones
// - p3 latch one: pin follows alternate output
// - p0 pull-up only for bus ones, else open-drain
// - reset sets every latch bit to one
// - latch loads at S6P2 of last cycle
// - buffers sample latch in phase 1 only
// - 0-to-1 boost during S1P1 and S1P2; the code boosts in S2P2 and S3P1
// - CMOS strong pull-up two oscillator periods
// - port two strong pull-up on address ones
// - read-modify-write reads latch, not pin
// - bit ops rewrite whole byte from latch
module qpb_port_bank
  import qpb_pkg::*;
#(
  parameter bit CMOS_BUILD = 1'b1,
  parameter bit THREE_TIMER = 1'b1
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] phase_idx,
  input wire logic [1:0] port_sel,
  input wire logic wr_latch,
  input wire logic last_cycle,
  input wire logic [7:0] wr_data,
  input wire logic bit_op,
  input wire logic [2:0] bit_idx,
  input wire logic bit_val,
  input wire qpb_pkg::qpb_rdsel_t rd_sel,
  input wire logic rmw_op,
  output logic [7:0] rd_data,
  input wire logic ext_access,
  input wire logic addr16,
  input wire logic [15:0] ext_addr,
  input wire logic addr_phase,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_wr_drive,
  output logic [7:0] ext_rdata,
  input wire logic ser_out,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  output logic ser_in,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic timer_a_count_input,
  output logic timer_b_count_input,
  output logic timer_c_count_input,
  output logic timer_c_capture_trigger,
  input wire logic [7:0] p0_pin_in,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p2_pin_in,
  input wire logic [7:0] p3_pin_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe,
  output logic [7:0] p1_strong_pullup,
  output logic [7:0] p2_strong_pullup,
  output logic [7:0] p3_strong_pullup
);
  import qpb_pkg::*;

  localparam int BOOST_LEN = CMOS_BUILD ? BOOST_OSC_PERIODS : 2;

  function automatic logic [7:0] pick(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] c, input logic [7:0] d);
    pick = (sel == PORT_ZERO) ? a : (sel == PORT_ONE) ? b : (sel == PORT_TWO) ? c : d;
  endfunction : pick

  logic [7:0] port_zero_latch, port_one_latch, port_two_latch, port_three_latch;
  logic [7:0] p0_lvl, p1_lvl, p2_lvl, p3_lvl;
  logic [7:0] buf0_q, buf1_q, buf2_q, buf3_q;
  logic [7:0] prev1_q, prev2_q, prev3_q;
  logic [7:0] boost1_q, boost2_q, boost3_q;
  logic [1:0] bcnt1_q [8];
  logic [1:0] bcnt2_q [8];
  logic [1:0] bcnt3_q [8];
  logic ext_q;

  qpb_pin_if pif0 ();

  qpb_pin_sync #(.W(32)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({p3_pin_in, p2_pin_in, p1_pin_in, p0_pin_in}),
    .pin_level({p3_lvl, p2_lvl, p1_lvl, p0_lvl})
  );

  // latch write path
  wire load_now = wr_latch & last_cycle & (phase_idx == PH_S6P2);
  wire [7:0] cur_latch = pick(port_sel, port_zero_latch, port_one_latch, port_two_latch, port_three_latch);
  wire [7:0] bit_mask = 8'h01 << bit_idx;
  wire [7:0] new_byte = bit_op ? ((cur_latch & ~bit_mask) | ({8{bit_val}} & bit_mask)) : wr_data;
  wire p1_phase = ~phase_idx[0];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port_zero_latch <= LATCH_RST;
      port_one_latch <= LATCH_RST;
      port_two_latch <= LATCH_RST;
      port_three_latch <= LATCH_RST;
    end
    else
    begin
      if (ext_access)
        port_zero_latch <= ALL_ONES;
      else if (load_now && port_sel == PORT_ZERO)
        port_zero_latch <= new_byte;
      if (load_now && port_sel == PORT_ONE)
        port_one_latch <= new_byte;
      if (load_now && port_sel == PORT_TWO && !ext_access)
        port_two_latch <= new_byte;
      if (load_now && port_sel == PORT_THREE)
        port_three_latch <= new_byte;
    end
  end

  // read path: rmw always reads latch
  wire [7:0] lat_rd = cur_latch;
  wire [7:0] pin_rd = pick(port_sel, p0_lvl, p1_lvl, p2_lvl, p3_lvl);
  wire use_latch = rmw_op | (rd_sel == QPB_RD_LATCH);
  wire [7:0] rd_d = use_latch ? lat_rd : (rd_sel == QPB_RD_PIN) ? pin_rd : 8'h00;

  // output buffers sample latches in phase 1 and hold in phase 2
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      buf0_q <= LATCH_RST;
      buf1_q <= LATCH_RST;
      buf2_q <= LATCH_RST;
      buf3_q <= LATCH_RST;
      ext_q <= 1'b0;
    end
    else if (p1_phase)
    begin
      buf0_q <= port_zero_latch;
      buf1_q <= port_one_latch;
      buf2_q <= port_two_latch;
      buf3_q <= port_three_latch;
      ext_q <= ext_access;
    end
  end

  // pin drive composition
  wire [7:0] p3_alt_out = {rd_strobe_n, wr_strobe_n, 4'hF, ser_out, 1'b1};
  wire [7:0] p3_level = buf3_q & p3_alt_out;
  wire [7:0] p1_level = buf1_q;
  wire [7:0] p0_bus = addr_phase ? ext_addr[7:0] : ext_wdata;
  wire p0_bus_drv = ext_q & (addr_phase | ext_wr_drive);
  wire [7:0] p0_out_d = p0_bus_drv ? p0_bus : 8'h00;
  wire [7:0] p0_oe_d = p0_bus_drv ? ALL_ONES : ~buf0_q;
  wire use_hi = ext_q & addr16;
  wire [7:0] p2_level = use_hi ? ext_addr[15:8] : buf2_q;

  assign pif0.drive_low = ~p0_oe_d;
  assign pif0.boost = 8'h00;
  assign pif0.pin_sync = p0_lvl;

  // boost pulse: strong pull-up for BOOST_LEN cycles, in S2P2 and S3P1, after a 0-to-1 change
  // compared at S1P2, the first edge at which the S1P1 buffer sample is visible;
  // comparing at S1P1 would see the old buffer and boost a whole machine cycle late
  wire s1_start = phase_idx == PH_S1P2;
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_boost
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          bcnt1_q[g] <= 2'h0;
          bcnt2_q[g] <= 2'h0;
          bcnt3_q[g] <= 2'h0;
        end
        else
        begin
          bcnt1_q[g] <= (s1_start && p1_level[g] && !prev1_q[g]) ? 2'(BOOST_LEN) :
                        (bcnt1_q[g] != 2'h0) ? bcnt1_q[g] - 2'h1 : 2'h0;
          bcnt2_q[g] <= (s1_start && p2_level[g] && !prev2_q[g]) ? 2'(BOOST_LEN) :
                        (bcnt2_q[g] != 2'h0) ? bcnt2_q[g] - 2'h1 : 2'h0;
          bcnt3_q[g] <= (s1_start && p3_level[g] && !prev3_q[g]) ? 2'(BOOST_LEN) :
                        (bcnt3_q[g] != 2'h0) ? bcnt3_q[g] - 2'h1 : 2'h0;
        end
      end
      assign boost1_q[g] = bcnt1_q[g] != 2'h0;
      assign boost2_q[g] = bcnt2_q[g] != 2'h0;
      assign boost3_q[g] = bcnt3_q[g] != 2'h0;
    end
  endgenerate

  // registered outputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
      ext_rdata <= 8'h00;
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p1_out <= LATCH_RST;
      p1_oe <= 8'h00;
      p2_out <= LATCH_RST;
      p2_oe <= 8'h00;
      p3_out <= LATCH_RST;
      p3_oe <= 8'h00;
      prev1_q <= LATCH_RST;
      prev2_q <= LATCH_RST;
      prev3_q <= LATCH_RST;
      p1_strong_pullup <= 8'h00;
      p2_strong_pullup <= 8'h00;
      p3_strong_pullup <= 8'h00;
      ser_in <= 1'b1;
      ext_irq_a <= 1'b1;
      ext_irq_b <= 1'b1;
      timer_a_count_input <= 1'b1;
      timer_b_count_input <= 1'b1;
      timer_c_count_input <= 1'b1;
      timer_c_capture_trigger <= 1'b1;
    end
    else
    begin
      rd_data <= rd_d;
      ext_rdata <= p0_lvl;
      p0_out <= p0_out_d;
      p0_oe <= p0_oe_d;
      // quasi-bidirectional: drive only zeros, pull-ups handled by strong_pullup
      p1_out <= p1_level;
      p1_oe <= ~p1_level;
      p2_out <= p2_level;
      p2_oe <= ~p2_level;
      p3_out <= p3_level;
      p3_oe <= ~p3_level;
      if (s1_start)
      begin
        prev1_q <= p1_level;
        prev2_q <= p2_level;
        prev3_q <= p3_level;
      end
      p1_strong_pullup <= boost1_q;
      p2_strong_pullup <= boost2_q | (use_hi ? ext_addr[15:8] : 8'h00);
      p3_strong_pullup <= boost3_q;
      ser_in <= p3_lvl[P3_SER_IN];
      ext_irq_a <= p3_lvl[P3_IRQ_A];
      ext_irq_b <= p3_lvl[P3_IRQ_B];
      timer_a_count_input <= p3_lvl[P3_TMR_A];
      timer_b_count_input <= p3_lvl[P3_TMR_B];
      timer_c_count_input <= THREE_TIMER ? p1_lvl[P1_TMR_C] : 1'b1;
      timer_c_capture_trigger <= THREE_TIMER ? p1_lvl[P1_TMR_C_TRIG] : 1'b1;
    end
  end

  a_latch_reset_ones: assert property (@(posedge ref_clk) $fell(rst) |-> port_one_latch == LATCH_RST)
    else $error("latch not all ones after reset");
  a_p0_ones_ext: assert property (@(posedge ref_clk) disable iff (rst) ext_access |=> port_zero_latch == ALL_ONES)
    else $error("port zero latch not ones during bus use");
  a_p2_kept_ext: assert property (@(posedge ref_clk) disable iff (rst) ext_access |=> $stable(port_two_latch))
    else $error("port two latch changed during bus use");
  a_load_timing: assert property (@(posedge ref_clk) disable iff (rst)
    (load_now && port_sel == PORT_ONE && !bit_op) |=> port_one_latch == $past(wr_data))
    else $error("latch did not load at end of cycle");
  a_rmw_latch: assert property (@(posedge ref_clk) disable iff (rst) rmw_op |=> rd_data == $past(lat_rd))
    else $error("rmw read did not return latch");
  a_p0_open_drain: assert property (@(posedge ref_clk) disable iff (rst) !ext_q |=> p0_oe == ~$past(buf0_q))
    else $error("port zero drove a one outside bus use");
  a_boost_len: assert property (@(posedge ref_clk) disable iff (rst) $rose(p1_strong_pullup[0]) |-> ##2 !p1_strong_pullup[0])
    else $error("strong pull-up not two periods");
  a_alt_forced_low: assert property (@(posedge ref_clk) disable iff (rst) !buf3_q[P3_WR_STB] |=> !p3_out[P3_WR_STB])
    else $error("alternate output ran with latch zero");

  // write to pin: load at S6P2, buffer at S1P1, pin register one edge later
  sequence s_p1_load;
    load_now && port_sel == PORT_ONE && !bit_op;
  endsequence : s_p1_load
  a_pin_after_load: assert property (@(posedge ref_clk) disable iff (rst)
    s_p1_load |=> ##2 p1_out == $past(wr_data, 3))
    else $error("latch value late on pin");
  a_p2_addr_hi: assert property (@(posedge ref_clk) disable iff (rst)
    (ext_q && addr16) |=> p2_out == $past(ext_addr[15:8]))
    else $error("port two not showing high address");
  a_p2_latch_lo: assert property (@(posedge ref_clk) disable iff (rst)
    (!ext_q || !addr16) |=> p2_out == $past(buf2_q))
    else $error("port two not showing its latch");
  a_p2_pullup_addr: assert property (@(posedge ref_clk) disable iff (rst)
    (ext_q && addr16) |=> (p2_strong_pullup & $past(ext_addr[15:8])) == $past(ext_addr[15:8]))
    else $error("port two address ones without strong pull-up");
  a_p0_bus_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (ext_q && addr_phase) |=> p0_oe == ALL_ONES && p0_out == $past(ext_addr[7:0]))
    else $error("port zero not driving address low byte");
  a_pin_read: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_sel == QPB_RD_PIN && !rmw_op) |=> rd_data == $past(pin_rd))
    else $error("pin read did not return pin level");
endmodule : qpb_port_bank

// *** testbench/qpb_pads_model.sv ***
// partner model: pads, pull-ups, external drivers and memory data
module qpb_pads_model
(
  input wire logic ref_clk,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_oe,
  input wire logic [7:0] ext_low1,
  input wire logic [7:0] ext_low3,
  input wire logic mem_en,
  input wire logic [7:0] mem_data,
  output logic [7:0] p0_pin_in,
  output logic [7:0] p1_pin_in,
  output logic [7:0] p2_pin_in,
  output logic [7:0] p3_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_q = 8'h55;
  // released open-drain lines wander every cycle
  always @(posedge ref_clk) float_q <= ~float_q;
  assign p0_pin_in = (p0_oe & p0_out) | (~p0_oe & (mem_en ? mem_data : float_q));
  assign p1_pin_in = (p1_oe & p1_out) | (~p1_oe & ~ext_low1);
  assign p2_pin_in = (p2_oe & p2_out) | ~p2_oe;
  assign p3_pin_in = (p3_oe & p3_out) | (~p3_oe & ~ext_low3);
endmodule : qpb_pads_model

// *** testbench/quasi_bidir_port_bank_tb.sv ***
// testbench: self-checking bench for the port bank
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module quasi_bidir_port_bank_tb;
  import qpb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst = 1'b1, wr_latch = 1'b0, last_cycle = 1'b0, bit_op = 1'b0, bit_val = 1'b0;
  logic rmw_op = 1'b0, ext_access = 1'b0, addr16 = 1'b0, addr_phase = 1'b0, mem_en = 1'b0, ser_out = 1'b1;
  logic ext_wr_drive = 1'b0;
  logic [7:0] ext_wdata = 8'h00;
  logic [3:0] phase_idx = 4'h0;
  logic [1:0] port_sel = 2'h0;
  logic [2:0] bit_idx = 3'h0;
  logic [7:0] wr_data = 8'h00, ext_low1 = 8'h00, ext_low3 = 8'h00, mem_data = 8'h00, d, n_boost;
  logic [15:0] ext_addr = 16'h0000;
  qpb_rdsel_t rd_sel = QPB_RD_NONE;
  logic [7:0] rd_data, ext_rdata, p0_pin_in, p1_pin_in, p2_pin_in, p3_pin_in;
  logic [7:0] p0_out, p0_oe, p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe, p1_strong_pullup, p2_strong_pullup;
  logic ext_irq_a;
  int n_fail = 0, checks_done = 0, cyc = 0;
  integer seed = 32'h9F447462;
  typedef struct {int sel; logic [7:0] exp;} qpb_note_t;
  qpb_note_t notes[$];
  event look_ev;
  string nm[11] = '{"rd_data", "p1_oe", "p2_oe", "p0_out", "p0_oe", "p2_pullup", "p3_oe", "irq_a",
                    "p1_pullup", "boost_len", "ext_rdata"};

  qpb_port_bank dut (.ref_clk, .rst, .phase_idx, .port_sel, .wr_latch, .last_cycle, .wr_data, .bit_op,
    .bit_idx, .bit_val, .rd_sel, .rmw_op, .rd_data, .ext_access, .addr16, .ext_addr, .addr_phase,
    .ext_wdata, .ext_wr_drive, .ext_rdata, .ser_out, .wr_strobe_n(1'b1), .rd_strobe_n(1'b1),
    .ser_in(), .ext_irq_a, .ext_irq_b(), .timer_a_count_input(), .timer_b_count_input(),
    .timer_c_count_input(), .timer_c_capture_trigger(), .p0_pin_in, .p1_pin_in, .p2_pin_in, .p3_pin_in,
    .p0_out, .p0_oe, .p1_out, .p1_oe, .p2_out, .p2_oe, .p3_out, .p3_oe, .p1_strong_pullup,
    .p2_strong_pullup, .p3_strong_pullup());
  qpb_pads_model pads (.ref_clk, .p0_out, .p0_oe, .p1_out, .p1_oe, .p2_out, .p2_oe, .p3_out, .p3_oe,
    .ext_low1, .ext_low3, .mem_en, .mem_data, .p0_pin_in, .p1_pin_in, .p2_pin_in, .p3_pin_in);

  initial forever #10 ref_clk = ~ref_clk;
  // machine-cycle sequencer stand-in
  always @(posedge ref_clk)
    phase_idx <= rst ? 4'h0 : ((phase_idx == 4'hB) ? 4'h0 : phase_idx + 4'h1);
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic expect_val(input int sel, input logic [7:0] exp);
    notes.push_back('{sel, exp});
    -> look_ev;
  endtask : expect_val
  // write request held so that the S6P2 edge takes it
  task automatic wr(input logic [1:0] p, input logic [7:0] v, input logic bop, input logic [2:0] bi);
    do @(posedge ref_clk); while (phase_idx !== 4'hA);
    port_sel <= p;
    wr_data <= v;
    bit_op <= bop;
    bit_idx <= bi;
    bit_val <= 1'b0;
    wr_latch <= 1'b1;
    last_cycle <= 1'b1;
    @(posedge ref_clk);
    wr_latch <= 1'b0;
    last_cycle <= 1'b0;
    bit_op <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] p, input qpb_rdsel_t s, input logic rmw, input logic [7:0] e);
    port_sel <= p;
    rd_sel <= s;
    rmw_op <= rmw;
    tick(3);
    expect_val(0, e);
    rd_sel <= QPB_RD_NONE;
    rmw_op <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  initial forever
  begin
    @(look_ev);
    #1;
    while (notes.size() > 0)
    begin
      qpb_note_t n;
      logic [7:0] s;
      n = notes.pop_front();
      case (n.sel)
        0: s = rd_data;
        1: s = p1_oe;
        2: s = p2_oe;
        3: s = p0_out;
        4: s = p0_oe;
        5: s = p2_strong_pullup;
        6: s = p3_oe;
        7: s = {7'h00, ext_irq_a};
        8: s = p1_strong_pullup;
        9: s = n_boost;
        default: s = ext_rdata;
      endcase
      `CHK(nm[n.sel], n.exp, s)
    end
  end

  initial
  begin
    tick(20);
    rst <= 1'b0;
    tick(2);
    rd(PORT_ONE, QPB_RD_LATCH, 1'b0, LATCH_RST);
    rd(PORT_THREE, QPB_RD_LATCH, 1'b0, LATCH_RST);
    expect_val(1, 8'h00);
    $display("test reset done");
    d = $random(seed) & 8'h7E;
    wr(PORT_ONE, d, 1'b0, 3'h0);
    rd(PORT_ONE, QPB_RD_LATCH, 1'b0, d);
    tick(12);
    expect_val(1, ~d);
    wr(PORT_ONE, ALL_ONES, 1'b0, 3'h0);
    n_boost = 8'h00;
    repeat (16)
    begin
      @(posedge ref_clk);
      #1;
      if (p1_strong_pullup === ~d)
        n_boost++;
    end
    expect_val(9, 8'h02);
    $display("test write and boost done");
    ext_low1 <= 8'h0F;
    tick(10);
    rd(PORT_ONE, QPB_RD_PIN, 1'b0, 8'hF0);
    rd(PORT_ONE, QPB_RD_PIN, 1'b1, 8'hFF);
    wr(PORT_ONE, 8'h00, 1'b1, 3'h6);
    rd(PORT_ONE, QPB_RD_LATCH, 1'b0, 8'hBF);
    ext_low1 <= 8'h00;
    $display("test pin and latch reads done");
    ser_out <= 1'b0;
    ext_low3 <= 8'h04;
    tick(10);
    expect_val(6, 8'h02);
    expect_val(7, 8'h00);
    ser_out <= 1'b1;
    wr(PORT_THREE, 8'h00, 1'b1, 3'h1);
    tick(12);
    expect_val(6, 8'h02);
    $display("test alternate functions done");
    wr(PORT_TWO, 8'h3C, 1'b0, 3'h0);
    wr(PORT_ZERO, 8'h00, 1'b0, 3'h0);
    ext_access <= 1'b1;
    addr16 <= 1'b1;
    ext_addr <= 16'hE1A5;
    addr_phase <= 1'b1;
    tick(6);
    expect_val(2, 8'h1E);
    expect_val(5, 8'hE1);
    expect_val(3, 8'hA5);
    expect_val(4, 8'hFF);
    wr(PORT_TWO, 8'h00, 1'b0, 3'h0);
    addr_phase <= 1'b0;
    addr16 <= 1'b0;
    mem_en <= 1'b1;
    mem_data <= 8'h96;
    tick(10);
    expect_val(2, 8'hC3);
    expect_val(10, 8'h96);
    expect_val(4, 8'h00);
    d = $random(seed);
    mem_en <= 1'b0;
    ext_wdata <= d;
    ext_wr_drive <= 1'b1;
    tick(4);
    expect_val(3, d);
    expect_val(4, 8'hFF);
    ext_wr_drive <= 1'b0;
    ext_access <= 1'b0;
    mem_en <= 1'b0;
    tick(4);
    rd(PORT_TWO, QPB_RD_LATCH, 1'b0, 8'h3C);
    rd(PORT_ZERO, QPB_RD_LATCH, 1'b0, ALL_ONES);
    $display("test external access done");
    tick(2);
    finish_test();
  end
endmodule : quasi_bidir_port_bank_tb
